// [design/cio_pkg.sv]
/*
 * Constants and carrier types for the increment-skip / OR / literal-load
 * execute slice of a 14-bit-instruction, 8-bit-data core.
 * Assumes one core clock; each instruction word is offered for one cycle.
 */

package cio_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 7;

    // ------------------------------------------------------------------
    // Field positions inside the instruction word
    // ------------------------------------------------------------------
    localparam int OP_HI    = 13;
    localparam int OP_LO    = 8;
    localparam int DEST_BIT = 7;
    localparam int ADDR_HI  = 6;
    localparam int LIT_HI   = 7;

    // ------------------------------------------------------------------
    // Opcode patterns (bits 13:8) and their compare masks
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_INC_SKIP   = 6'h0f;  // 00 1111
    localparam logic [5:0] OPC_OR_REG     = 6'h04;  // 00 0100
    localparam logic [5:0] OPC_OR_LIT     = 6'h38;  // 11 1000
    localparam logic [5:0] OPC_MOVE_LIT   = 6'h30;  // 11 00xx
    localparam logic [5:0] MASK_FULL      = 6'h3f;
    localparam logic [5:0] MASK_MOVE_LIT  = 6'h3c;

    // ------------------------------------------------------------------
    // Destination select values
    // ------------------------------------------------------------------
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ACC  = 8'h00;
    localparam logic       RST_ZERO = 1'b0;
    localparam logic [6:0] RST_ADDR = 7'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cio_file_wr_t;

    typedef enum logic [2:0] {
        CIO_OP_NONE,
        CIO_OP_INC_SKIP,
        CIO_OP_OR_REG,
        CIO_OP_OR_LIT,
        CIO_OP_MOVE_LIT
    } cio_op_t;

endpackage

// [design/cio_exec.sv]
/*
 * Execute slice for four single-word instructions: increment file register
 * and skip if the sum is zero, OR accumulator with file register, OR
 * accumulator with literal, and load literal into accumulator.
 * Assumes the core fetch stage offers one instruction word per cycle with
 * i_instr_valid, and that i_file_rdata holds the register addressed by that
 * word in the same cycle. All inputs are on i_clock.
 */

`timescale 1ns/1ns
`default_nettype none

module cio_exec (
    // Clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    // Instruction from fetch
    input  wire logic                      i_instr_valid,
    input  wire logic [cio_pkg::INSTR_W-1:0] i_instr,
    // Operand read from the file
    input  wire logic [cio_pkg::DATA_W-1:0]  i_file_rdata,
    // Architectural state
    output logic      [cio_pkg::DATA_W-1:0]  o_acc,
    output logic                           o_zero,
    // File write-back
    output cio_pkg::cio_file_wr_t          o_file_wr,
    // Sequencing
    output logic                           o_executed,
    output logic                           o_discarded,
    output logic                           o_skip_pending,
    output logic                           o_foreign
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [cio_pkg::DATA_W-1:0] acc_q;
    logic [cio_pkg::DATA_W-1:0] acc_d;
    logic                       zero_q;
    logic                       zero_d;
    cio_pkg::cio_file_wr_t      wr_q;
    cio_pkg::cio_file_wr_t      wr_d;
    logic                       skip_q;
    logic                       skip_d;
    logic                       exec_q;
    logic                       disc_q;
    logic                       foreign_q;

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    wire logic [5:0]                 opc_w;
    wire logic                       dest_w;
    wire logic [cio_pkg::ADDR_W-1:0] faddr_w;
    wire logic [cio_pkg::DATA_W-1:0] lit_w;

    assign opc_w   = i_instr[cio_pkg::OP_HI:cio_pkg::OP_LO];
    assign dest_w  = i_instr[cio_pkg::DEST_BIT];
    assign faddr_w = i_instr[cio_pkg::ADDR_HI:0];
    assign lit_w   = i_instr[cio_pkg::LIT_HI:0];

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic      hit_inc_w;
    wire logic      hit_orr_w;
    wire logic      hit_orl_w;
    wire logic      hit_mov_w;
    wire logic      live_w;
    cio_pkg::cio_op_t op_w;

    assign hit_inc_w = (opc_w & cio_pkg::MASK_FULL) == cio_pkg::OPC_INC_SKIP;
    assign hit_orr_w = (opc_w & cio_pkg::MASK_FULL) == cio_pkg::OPC_OR_REG;
    assign hit_orl_w = (opc_w & cio_pkg::MASK_FULL) == cio_pkg::OPC_OR_LIT;
    // Bits 9:8 are masked out so any assembler filler decodes the same
    assign hit_mov_w = (opc_w & cio_pkg::MASK_MOVE_LIT) == cio_pkg::OPC_MOVE_LIT;

    // A word fetched behind a zero-sum increment is never executed
    assign live_w = i_instr_valid && !skip_q;

    assign op_w = !live_w   ? cio_pkg::CIO_OP_NONE :
                  hit_inc_w ? cio_pkg::CIO_OP_INC_SKIP :
                  hit_orr_w ? cio_pkg::CIO_OP_OR_REG :
                  hit_orl_w ? cio_pkg::CIO_OP_OR_LIT :
                  hit_mov_w ? cio_pkg::CIO_OP_MOVE_LIT :
                              cio_pkg::CIO_OP_NONE;

    // ------------------------------------------------------------------
    // Operand forwarding
    // ------------------------------------------------------------------
    // The write-back lands one cycle late, so a back-to-back read of the
    // same register would otherwise see the stale file value.
    // Only the last write-back is held: the file must take each write at once.
    wire logic                       fwd_w;
    wire logic [cio_pkg::DATA_W-1:0] fval_w;

    assign fwd_w  = wr_q.we && (wr_q.addr == faddr_w);
    assign fval_w = fwd_w ? wr_q.data : i_file_rdata;

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    wire logic [cio_pkg::DATA_W-1:0] inc_w;
    wire logic [cio_pkg::DATA_W-1:0] orr_w;
    wire logic [cio_pkg::DATA_W-1:0] orl_w;
    wire logic                       inc_zero_w;
    wire logic                       orr_zero_w;
    wire logic                       orl_zero_w;

    assign inc_w      = cio_pkg::DATA_W'(fval_w + 8'h01);
    assign orr_w      = acc_q | fval_w;
    assign orl_w      = acc_q | lit_w;
    assign inc_zero_w = inc_w == 8'h00;
    assign orr_zero_w = orr_w == 8'h00;
    assign orl_zero_w = orl_w == 8'h00;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Only the two OR forms write zero_d; the increment and the literal
    // load must leave the flag exactly as the previous instruction set it.
    always_comb begin
        acc_d  = acc_q;
        zero_d = zero_q;
        wr_d   = '{we: 1'b0, addr: faddr_w, data: cio_pkg::RST_DATA};
        skip_d = 1'b0;
        unique case (op_w)
            cio_pkg::CIO_OP_INC_SKIP: begin
                // Status flags deliberately left alone
                if (dest_w == cio_pkg::DEST_FILE) begin
                    wr_d.we   = 1'b1;
                    wr_d.data = inc_w;
                end else begin
                    acc_d = inc_w;
                end
                skip_d = inc_zero_w;
            end
            cio_pkg::CIO_OP_OR_REG: begin
                if (dest_w == cio_pkg::DEST_FILE) begin
                    wr_d.we   = 1'b1;
                    wr_d.data = orr_w;
                end else begin
                    acc_d = orr_w;
                end
                zero_d = orr_zero_w;
            end
            cio_pkg::CIO_OP_OR_LIT: begin
                acc_d  = orl_w;
                zero_d = orl_zero_w;
            end
            cio_pkg::CIO_OP_MOVE_LIT: begin
                acc_d = lit_w;
            end
            cio_pkg::CIO_OP_NONE: begin
                acc_d = acc_q;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            acc_q  <= cio_pkg::RST_ACC;
            zero_q <= cio_pkg::RST_ZERO;
            wr_q   <= '{we: 1'b0, addr: cio_pkg::RST_ADDR, data: cio_pkg::RST_DATA};
        end else begin
            acc_q  <= acc_d;
            zero_q <= zero_d;
            wr_q   <= wr_d;
        end
    end

    // Skip stays armed until the next fetched word arrives, however late
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            skip_q <= 1'b0;
        end else if (i_instr_valid) begin
            skip_q <= skip_d;
        end
    end

    // Status pulses only; nothing here feeds back into the datapath
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            exec_q    <= 1'b0;
            disc_q    <= 1'b0;
            foreign_q <= 1'b0;
        end else begin
            exec_q    <= op_w != cio_pkg::CIO_OP_NONE;
            disc_q    <= i_instr_valid && skip_q;
            foreign_q <= live_w && (op_w == cio_pkg::CIO_OP_NONE);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_acc          = acc_q;
    assign o_zero         = zero_q;
    assign o_file_wr      = wr_q;
    assign o_executed     = exec_q;
    assign o_discarded    = disc_q;
    assign o_skip_pending = skip_q;
    assign o_foreign      = foreign_q;

endmodule

`default_nettype wire

// [tb/cio_exec_props.sv]
/* Assertions on the cio_exec ports.
   Assumes one clock with a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module cio_exec_props (
    // Clock, reset and inputs
    input wire logic                  i_clock,
    input wire logic                  i_rst,
    input wire logic                  i_instr_valid,
    input wire logic [13:0]           i_instr,
    input wire logic [7:0]            i_file_rdata,
    // Outputs
    input wire logic [7:0]            o_acc,
    input wire logic                  o_zero,
    input wire cio_pkg::cio_file_wr_t o_file_wr,
    input wire logic                  o_executed,
    input wire logic                  o_discarded,
    input wire logic                  o_skip_pending,
    input wire logic                  o_foreign
);
    wire logic [5:0] op = i_instr[13:8];
    wire logic live = i_instr_valid && !o_skip_pending;
    // Operand as the design sees it, with the last write-back forwarded
    wire logic [7:0] opd = (o_file_wr.we && o_file_wr.addr == i_instr[6:0]) ?
                           o_file_wr.data : i_file_rdata;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    inc_write_a: assert property (live && op == 6'h0f && i_instr[7] |=> o_file_wr.we &&
        o_file_wr.addr == $past(i_instr[6:0]) && o_file_wr.data == $past(opd) + 8'h01 &&
        $stable(o_zero)) else $error("increment write-back wrong");
    inc_acc_a: assert property (live && op == 6'h0f && !i_instr[7] |=> !o_file_wr.we &&
        o_acc == $past(opd) + 8'h01 && $stable(o_zero)) else $error("increment to accumulator wrong");
    skip_arm_a: assert property (live && op == 6'h0f && opd == 8'hff |=> o_skip_pending)
        else $error("skip not armed");
    discard_word_a: assert property (i_instr_valid && o_skip_pending |=> o_discarded &&
        !o_executed && !o_file_wr.we && $stable(o_acc)) else $error("word not discarded");
    or_reg_a: assert property (live && op == 6'h04 |=> o_executed &&
        o_zero == (($past(o_acc) | $past(opd)) == 8'h00)) else $error("or register flag wrong");
    or_lit_a: assert property (live && op == 6'h38 |=> o_acc == ($past(o_acc) |
        $past(i_instr[7:0])) && o_zero == (o_acc == 8'h00)) else $error("or literal wrong");
    move_lit_a: assert property (live && op[5:2] == 4'hc |=> o_acc == $past(i_instr[7:0])
        && $stable(o_zero)) else $error("literal load wrong");
    foreign_quiet_a: assert property (o_foreign |-> o_acc == $past(o_acc) && !o_file_wr.we)
        else $error("foreign word changed state");
    idle_quiet_a: assert property (!i_instr_valid |=> !o_executed && !o_file_wr.we)
        else $error("activity without a word");
endmodule
bind cio_exec cio_exec_props chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_file_rdata(i_file_rdata),
    .o_acc(o_acc), .o_zero(o_zero), .o_file_wr(o_file_wr), .o_executed(o_executed),
    .o_discarded(o_discarded), .o_skip_pending(o_skip_pending), .o_foreign(o_foreign));
`default_nettype wire

// [tb/cio_exec_tb.sv]
/* Self-checking bench for cio_exec.
   Assumes the bench itself stands in for fetch and the register file. */
`timescale 1ns/1ns
`default_nettype none
module cio_exec_tb;
    logic                  i_clock = 1'b0;
    logic                  i_rst = 1'b1;
    logic                  i_instr_valid = 1'b0;
    logic [13:0]           i_instr = 14'h0000;
    logic [7:0]            i_file_rdata = 8'h00;
    logic [7:0]            o_acc;
    logic                  o_zero;
    cio_pkg::cio_file_wr_t o_file_wr;
    logic                  o_executed, o_discarded, o_skip_pending, o_foreign;
    int                    fail_count = 0;
    int                    comparisons = 0;
    always #2 i_clock = ~i_clock;
    cio_exec uut (.i_clock(i_clock), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_acc(o_acc), .o_zero(o_zero),
        .o_file_wr(o_file_wr), .o_executed(o_executed), .o_discarded(o_discarded),
        .o_skip_pending(o_skip_pending), .o_foreign(o_foreign));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // One word, then a gap; outputs are read once the taking edge has landed
    task automatic op(input logic [13:0] w, input logic [7:0] rd);
        @(posedge i_clock);
        i_instr_valid <= 1'b1;
        i_instr       <= w;
        i_file_rdata  <= rd;
        @(posedge i_clock);
        i_instr_valid <= 1'b0;
        #1;
    endtask
    task automatic t_or_lit;
        op(14'h309a, 8'h00);
        op(14'h3835, 8'h00);
        chk("acc", 8'hbf, o_acc);
        chk("zero", 8'h00, 8'(o_zero));
        chk("exec", 8'h01, 8'(o_executed));
        op(14'h3000, 8'h00);
        op(14'h3800, 8'h00);
        chk("zero", 8'h01, 8'(o_zero));
    endtask
    task automatic t_move;
        for (int j = 0; j < 4; j++) begin
            op({4'hc, 2'(j), 8'hff - 8'(j)}, 8'h00);
            chk("acc", 8'hff - 8'(j), o_acc);
            chk("zero", 8'h01, 8'(o_zero));
        end
    endtask
    // Zero flag is cleared first so that a zero sum cannot pass by luck
    task automatic t_inc;
        op(14'h3801, 8'h00);
        chk("zero", 8'h00, 8'(o_zero));
        op(14'h0f85, 8'hfe);
        chk("we", 8'h01, 8'(o_file_wr.we));
        chk("addr", 8'h05, 8'(o_file_wr.addr));
        chk("data", 8'hff, o_file_wr.data);
        chk("skip", 8'h00, 8'(o_skip_pending));
        chk("zero", 8'h00, 8'(o_zero));
        op(14'h0f7f, 8'hff);
        chk("acc", 8'h00, o_acc);
        chk("we", 8'h00, 8'(o_file_wr.we));
        chk("zero", 8'h00, 8'(o_zero));
        chk("skip", 8'h01, 8'(o_skip_pending));
        op(14'h3077, 8'h00);
        chk("disc", 8'h01, 8'(o_discarded));
        chk("exec", 8'h00, 8'(o_executed));
        chk("acc", 8'h00, o_acc);
        op(14'h3077, 8'h00);
        chk("acc", 8'h77, o_acc);
    endtask
    task automatic t_or_reg;
        op(14'h3091, 8'h00);
        op(14'h047f, 8'h13);
        chk("acc", 8'h93, o_acc);
        chk("zero", 8'h00, 8'(o_zero));
        chk("we", 8'h00, 8'(o_file_wr.we));
        op(14'h3000, 8'h00);
        op(14'h04aa, 8'h00);
        chk("we", 8'h01, 8'(o_file_wr.we));
        chk("addr", 8'h2a, 8'(o_file_wr.addr));
        chk("data", 8'h00, o_file_wr.data);
        chk("zero", 8'h01, 8'(o_zero));
    endtask
    task automatic t_foreign;
        op(14'h0a05, 8'h10);
        chk("foreign", 8'h01, 8'(o_foreign));
        chk("acc", 8'h00, o_acc);
        chk("exec", 8'h00, 8'(o_executed));
        chk("zero", 8'h01, 8'(o_zero));
    endtask
    // Words on consecutive edges: the second increment sees the first sum
    // only through forwarding, and the word behind it must be dropped
    task automatic t_back;
        @(posedge i_clock);
        i_instr_valid <= 1'b1;
        i_instr       <= 14'h3011;
        i_file_rdata  <= 8'h00;
        @(posedge i_clock);
        i_instr       <= 14'h0f85;
        i_file_rdata  <= 8'hfe;
        #1;
        chk("acc", 8'h11, o_acc);
        @(posedge i_clock);
        #1;
        chk("data", 8'hff, o_file_wr.data);
        chk("skip", 8'h00, 8'(o_skip_pending));
        @(posedge i_clock);
        i_instr       <= 14'h3055;
        #1;
        chk("data", 8'h00, o_file_wr.data);
        chk("skip", 8'h01, 8'(o_skip_pending));
        @(posedge i_clock);
        i_instr       <= 14'h3066;
        #1;
        chk("disc", 8'h01, 8'(o_discarded));
        chk("acc", 8'h11, o_acc);
        @(posedge i_clock);
        i_instr_valid <= 1'b0;
        #1;
        chk("acc", 8'h66, o_acc);
        chk("disc", 8'h00, 8'(o_discarded));
        chk("exec", 8'h01, 8'(o_executed));
    endtask
    // A reset in mid-run drops a pending skip and the architectural state
    task automatic t_reset;
        op(14'h3000, 8'h00);
        op(14'h3800, 8'h00);
        op(14'h30a5, 8'h00);
        op(14'h0f81, 8'hff);
        chk("skip", 8'h01, 8'(o_skip_pending));
        chk("acc", 8'ha5, o_acc);
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        #1;
        chk("acc", 8'h00, o_acc);
        chk("zero", 8'h00, 8'(o_zero));
        chk("skip", 8'h00, 8'(o_skip_pending));
        op(14'h3042, 8'h00);
        chk("disc", 8'h00, 8'(o_discarded));
        chk("acc", 8'h42, o_acc);
    endtask
    task automatic stop_test;
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Whole sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge i_clock);
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        t_or_lit();
        t_move();
        t_inc();
        t_or_reg();
        t_foreign();
        t_back();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
